// *** hw/ext_bus_ctrl.sv ***
`timescale 1ns/10ps
module ext_bus_ctrl
  import ebus_pkg::*;
(
  // Clock and reset; clk stands for the external clock input.
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Asynchronous control pins.
  input  wire logic                          program_mode_select,
  input  wire logic                          low_power_request_n,
  input  wire logic                          lp_edge_mode,
  input  wire logic                          halt_n,
  input  wire logic                          nop_n,
  input  wire logic                          level_branch_input,
  input  wire logic                          edge_branch_input_a,
  input  wire logic                          edge_branch_input_b,
  // Branch condition flags toward the core; the core masks them.
  output logic     [2:0]                     branch_cond,
  input  wire logic [1:0]                    branch_edge_clr,
  // Core data access request.
  input  wire logic                          core_req,
  input  wire logic                          core_wr,
  input  wire logic                          core_space_e,
  input  wire logic [ebus_pkg::WORD_ADDR_W-1:0] core_addr,
  input  wire logic [ebus_pkg::DATA_W-1:0]   core_wdata,
  input  wire logic                          strobe_mode,
  // Page registers written by the core.
  input  wire logic                          page_e_we,
  input  wire logic                          page_c_we,
  input  wire logic [ebus_pkg::PAGE_W-1:0]   page_wdata,
  output logic     [ebus_pkg::DATA_W-1:0]    core_rdata,
  output logic                               internal_sel,
  // Local data bus pins.
  input  wire logic [ebus_pkg::DATA_W-1:0]   local_data_bus_in,
  output logic     [ebus_pkg::DATA_W-1:0]    local_data_bus_out,
  output logic                               local_data_bus_oe,
  output logic     [ebus_pkg::ADDR_W-1:0]    local_addr_bus,
  output logic                               local_addr_bus_oe,
  output logic                               ext_space_sel_n,
  output logic                               data_strobe_n,
  output logic                               write_dir_n,
  // Instruction bus and program memory pins.
  input  wire logic                          host_prog_wr,
  input  wire logic [ebus_pkg::IADDR_W-1:0]  host_prog_addr,
  input  wire logic [ebus_pkg::IDATA_W-1:0]  host_prog_data,
  input  wire logic                          branch_take,
  input  wire logic [ebus_pkg::IADDR_W-1:0]  branch_target,
  input  wire logic [ebus_pkg::IDATA_W-1:0]  instr_data_bus_in,
  output logic     [ebus_pkg::IDATA_W-1:0]   instr_data_bus_out,
  output logic                               instr_data_bus_oe,
  output logic     [ebus_pkg::IADDR_W-1:0]   instr_addr_bus,
  output logic                               instr_addr_bus_oe,
  output logic                               ext_prog_mem_enable_n,
  output logic                               prog_mem_write_n,
  output logic     [ebus_pkg::IDATA_W-1:0]   fetched_instr,
  output logic                               instr_is_nop,
  // Run state and clocks.
  output logic                               low_power_ack_n,
  output logic                               machine_cycle_clock,
  output logic                               instruction_cycle_clock
);
  import ebus_pkg::*;

  sync_if sy ();
  assign sy.raw = {low_power_request_n, halt_n, nop_n, level_branch_input,
                   edge_branch_input_a, edge_branch_input_b};
  pin_sync u_sync (
    .clk (clk),
    .rst (rst),
    .s   (sy)
  );

  logic             lp_s, halt_s, nop_s, bs_s, bea_s, beb_s;
  assign {lp_s, halt_s, nop_s, bs_s, bea_s, beb_s} = sy.synced;

  function automatic logic is_internal(input logic [PAGE_W-1:0] pg);
    return pg <= LAST_INT_PAGE;
  endfunction

  // Divider and instruction phase.
  logic             div_ff;
  logic             run_clk_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff <= 1'b0;
    end else begin
      div_ff <= ~div_ff;
    end
  end
  assign machine_cycle_clock = div_ff;
  // Instruction boundary: the cycle in which the divided clock is about to rise.
  logic             boundary;
  assign boundary = ~div_ff;

  // Run state machine.
  run_state_t       state_ff;
  logic             lp_prev_ff;
  logic             lp_pend_ff;
  logic             lp_fall;
  assign lp_fall = lp_prev_ff & ~lp_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      lp_prev_ff <= 1'b1;
    end else begin
      lp_prev_ff <= lp_s;
    end
  end

  // Edge requests are held until taken at an instruction boundary.
  always_ff @(posedge clk) begin
    if (rst) begin
      lp_pend_ff <= 1'b0;
    end else if (lp_edge_mode && lp_fall) begin
      lp_pend_ff <= 1'b1;
    end else if (boundary && state_ff == LOWPWR_ST) begin
      lp_pend_ff <= 1'b0;
    end
  end

  logic             lp_want;
  assign lp_want = lp_edge_mode ? lp_pend_ff : ~lp_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= RUN_ST;
    end else if (boundary) begin
      case (state_ff)
        RUN_ST: begin
          if (lp_want) begin
            state_ff <= LOWPWR_ST;
          end else if (!halt_s) begin
            state_ff <= HALT_ST;
          end else if (!nop_s) begin
            state_ff <= FLOAT_ST;
          end
        end
        LOWPWR_ST: begin
          if (lp_edge_mode ? lp_s : lp_s && !lp_pend_ff) begin
            state_ff <= RUN_ST;
          end
        end
        HALT_ST: begin
          if (halt_s) begin
            state_ff <= RUN_ST;
          end
        end
        FLOAT_ST: begin
          if (nop_s) begin
            state_ff <= RUN_ST;
          end
        end
        default: state_ff <= RUN_ST;
      endcase
    end
  end

  logic             running;
  assign running = (state_ff == RUN_ST);
  assign low_power_ack_n = (state_ff != LOWPWR_ST);
  // The instruction clock stops while halted or in low power, keeping state.
  assign instruction_cycle_clock = div_ff &
                                   (running || state_ff == FLOAT_ST);

  // Program counter advances only at an instruction boundary.
  logic [IADDR_W-1:0] pc_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_ff <= PC_RESET;
    end else if (boundary && running) begin
      pc_ff <= branch_take ? branch_target : pc_ff + 16'h0001;
    end
  end

  // The mode pin is static in use but still comes from outside the clock domain.
  logic             pmode_meta_ff;
  logic             pmode_s_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      pmode_meta_ff <= 1'b0;
      pmode_s_ff    <= 1'b0;
    end else begin
      pmode_meta_ff <= program_mode_select;
      pmode_s_ff    <= pmode_meta_ff;
    end
  end

  // Program memory selection.
  logic             ext_fetch;
  assign ext_fetch = pmode_s_ff || (pc_ff > INT_PROG_TOP);
  logic             prog_wr_act;
  assign prog_wr_act = host_prog_wr && running && !rst;

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_prog_mem_enable_n <= 1'b1;
      prog_mem_write_n      <= 1'b1;
      instr_addr_bus        <= PC_RESET;
      instr_data_bus_out    <= '0;
      instr_data_bus_oe     <= 1'b0;
      instr_addr_bus_oe     <= 1'b0;
    end else begin
      ext_prog_mem_enable_n <= ~(running && (ext_fetch || prog_wr_act));
      prog_mem_write_n      <= ~prog_wr_act;
      instr_addr_bus        <= prog_wr_act ? host_prog_addr : pc_ff;
      instr_data_bus_out    <= host_prog_data;
      instr_data_bus_oe     <= prog_wr_act;
      // Halt and float both release the instruction address pins.
      instr_addr_bus_oe     <= running;
    end
  end

  // Fetched word latched at the boundary; nop forced outside normal running.
  always_ff @(posedge clk) begin
    if (rst) begin
      fetched_instr <= '0;
      instr_is_nop  <= 1'b1;
    end else if (boundary) begin
      fetched_instr <= instr_data_bus_in;
      instr_is_nop  <= !running;
    end
  end

  // Page registers, one per data space.
  logic [PAGE_W-1:0] page_e_ff, page_c_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      page_e_ff <= PAGE_RESET;
      page_c_ff <= PAGE_RESET;
    end else begin
      if (page_e_we) begin
        page_e_ff <= page_wdata;
      end
      if (page_c_we) begin
        page_c_ff <= page_wdata;
      end
    end
  end

  logic [PAGE_W-1:0] cur_page;
  assign cur_page = core_space_e ? page_e_ff : page_c_ff;
  // Peripherals and internal memory are answered on-chip for both spaces.
  assign internal_sel = core_req && is_internal(cur_page);

  logic             ext_act;
  assign ext_act = core_req && running && !is_internal(cur_page);

  // Local bus pins, registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      local_addr_bus     <= ADDR_IDLE;
      ext_space_sel_n    <= 1'b1;
      data_strobe_n      <= 1'b1;
      write_dir_n        <= 1'b1;
      local_data_bus_out <= '0;
      local_data_bus_oe  <= 1'b0;
      local_addr_bus_oe  <= 1'b0;
    end else begin
      local_addr_bus     <= ext_act ? {cur_page, core_addr} : ADDR_IDLE;
      ext_space_sel_n    <= ~ext_act;
      if (strobe_mode) begin
        data_strobe_n <= ~ext_act;
        write_dir_n   <= ~(ext_act && core_wr);
      end else begin
        data_strobe_n <= ~(ext_act && !core_wr);
        write_dir_n   <= ~(ext_act && core_wr);
      end
      local_data_bus_out <= core_wdata;
      local_data_bus_oe  <= ext_act && core_wr && lp_s;
      local_addr_bus_oe  <= state_ff != FLOAT_ST;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      core_rdata <= '0;
    end else if (!ext_space_sel_n && write_dir_n) begin
      // Read data is only valid once the read exchange stands on the pins.
      core_rdata <= local_data_bus_in;
    end
  end

  // Branch inputs: level input passes inverted; edge inputs latch a falling edge.
  logic             bea_prev_ff, beb_prev_ff;
  logic [1:0]       edge_flag_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      bea_prev_ff <= 1'b1;
      beb_prev_ff <= 1'b1;
    end else begin
      bea_prev_ff <= bea_s;
      beb_prev_ff <= beb_s;
    end
  end

  // A new edge in the clearing cycle wins, so no event is lost.
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_flag_ff <= 2'b00;
    end else begin
      edge_flag_ff[0] <= (bea_prev_ff & ~bea_s) | (edge_flag_ff[0] & ~branch_edge_clr[0]);
      edge_flag_ff[1] <= (beb_prev_ff & ~beb_s) | (edge_flag_ff[1] & ~branch_edge_clr[1]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      branch_cond <= 3'h0;
    end else begin
      branch_cond <= {edge_flag_ff, ~bs_s};
    end
  end

  a_low_power_ack_n_tracks_state: assert property (@(posedge clk) disable iff (rst)
    (state_ff == LOWPWR_ST) |-> !low_power_ack_n)
    else $error("low power ack not low in low power");
  a_idle_addr_ones: assert property (@(posedge clk) disable iff (rst)
    !ext_act |=> local_addr_bus == ADDR_IDLE)
    else $error("idle address not all ones");
  a_cs_above_16k: assert property (@(posedge clk) disable iff (rst)
    !ext_space_sel_n |-> local_addr_bus[15:12] > LAST_INT_PAGE)
    else $error("select low for internal address");
  a_data_float_idle: assert property (@(posedge clk) disable iff (rst)
    local_data_bus_oe |-> !write_dir_n && !ext_space_sel_n)
    else $error("data bus driven without write exchange");
  a_clk_halves: assert property (@(posedge clk) disable iff (rst)
    machine_cycle_clock |=> !machine_cycle_clock ##1 machine_cycle_clock)
    else $error("machine clock not divided by two");
  a_halt_floats_ia: assert property (@(posedge clk) disable iff (rst)
    (state_ff == HALT_ST) |=> !instr_addr_bus_oe)
    else $error("instruction address driven while halted");
  a_wpm_on_write: assert property (@(posedge clk) disable iff (rst)
    !prog_mem_write_n |-> instr_data_bus_oe && !ext_prog_mem_enable_n)
    else $error("program write strobe without data drive");
  a_edge_flag_set: assert property (@(posedge clk) disable iff (rst)
    (bea_prev_ff && !bea_s) |=> edge_flag_ff[0] ##1 branch_cond[1])
    else $error("falling edge not latched");
  a_pc_held_stop: assert property (@(posedge clk) disable iff (rst)
    (state_ff == LOWPWR_ST && $past(state_ff) == LOWPWR_ST) |-> $stable(pc_ff))
    else $error("program counter moved in low power");
endmodule // ext_bus_ctrl

// *** hw/ebus_pkg.sv ***
package ebus_pkg;
  // Local data bus geometry.
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned WORD_ADDR_W = 12;
  localparam int unsigned PAGE_W      = 4;
  localparam int unsigned ADDR_W      = 16;
  // Instruction bus geometry.
  localparam int unsigned IDATA_W     = 32;
  localparam int unsigned IADDR_W     = 16;
  // Pages 0 to 3 hold the on-chip 16k region.
  localparam logic [3:0]  LAST_INT_PAGE = 4'h3;
  localparam logic [15:0] ADDR_IDLE     = 16'hffff;
  localparam logic [15:0] PC_RESET      = 16'h0000;
  // Internal program memory spans the low 16k words.
  localparam logic [15:0] INT_PROG_TOP  = 16'h3fff;
  localparam logic [3:0]  PAGE_RESET    = 4'h0;
  // Machine cycle is two input clocks.
  localparam int unsigned CLK_DIV       = 2;
  typedef enum logic [1:0] {RUN_ST, HALT_ST, LOWPWR_ST, FLOAT_ST} run_state_t;
endpackage

// *** hw/sync_if.sv ***
`timescale 1ns/10ps
interface sync_if;
  logic [5:0] raw;
  logic [5:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

// *** hw/pin_sync.sv ***
`timescale 1ns/10ps
module pin_sync (
  input wire logic clk,
  input wire logic rst,
  sync_if.dst      s
);
  logic [5:0] meta_ff;
  logic [5:0] sync_ff;

  // Inputs are active low, so they rest high out of reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 6'h3f;
      sync_ff <= 6'h3f;
    end else begin
      meta_ff <= s.raw;
      sync_ff <= meta_ff;
    end
  end
  assign s.synced = sync_ff;
endmodule // pin_sync

// *** dv/ext_mem_model.sv ***
`timescale 1ns/10ps
module ext_mem_model
  import ebus_pkg::*;
(
  // Clock and strobe style.
  input  wire logic                         clk,
  input  wire logic                         strobe_mode,
  // Local data side.
  input  wire logic [ebus_pkg::ADDR_W-1:0]  local_addr_bus,
  input  wire logic                         ext_space_sel_n,
  input  wire logic                         data_strobe_n,
  input  wire logic                         write_dir_n,
  input  wire logic [ebus_pkg::DATA_W-1:0]  ldata_wire,
  output logic      [ebus_pkg::DATA_W-1:0]  ldata_drv,
  // Program memory side.
  input  wire logic [ebus_pkg::IADDR_W-1:0] instr_addr_bus,
  input  wire logic                         ext_prog_mem_enable_n,
  input  wire logic                         prog_mem_write_n,
  input  wire logic [ebus_pkg::IDATA_W-1:0] idata_wire,
  output logic      [ebus_pkg::IDATA_W-1:0] idata_drv
);
  logic [DATA_W-1:0]  dmem [256];
  logic [IDATA_W-1:0] pmem [256];
  logic [DATA_W-1:0]  junk_ff = 16'h5a5a;
  logic [IDATA_W-1:0] ijunk_ff = 32'h3c3c_a5a5;
  logic               rd;
  logic               wr;
  assign rd = !ext_space_sel_n && !data_strobe_n && (write_dir_n || !strobe_mode);
  assign wr = !ext_space_sel_n && !write_dir_n && (!data_strobe_n || !strobe_mode);
  // Released lines toggle each cycle, so a stale value never passes for read data.
  assign ldata_drv = rd ? dmem[local_addr_bus[7:0]] : junk_ff;
  assign idata_drv = (!ext_prog_mem_enable_n && prog_mem_write_n) ?
                     pmem[instr_addr_bus[7:0]] : ijunk_ff;
  always @(posedge clk) begin
    junk_ff <= ~junk_ff;
    ijunk_ff <= ~ijunk_ff;
    if (wr) dmem[local_addr_bus[7:0]] <= ldata_wire;
    if (!prog_mem_write_n) pmem[instr_addr_bus[7:0]] <= idata_wire;
  end
endmodule // ext_mem_model

// *** dv/ext_bus_ctrl_tb.sv ***
`timescale 1ns/10ps
module ext_bus_ctrl_tb;
  import ebus_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic program_mode_select, low_power_request_n, lp_edge_mode, halt_n, nop_n;
  logic level_branch_input, edge_branch_input_a, edge_branch_input_b;
  logic [2:0] branch_cond;
  logic [1:0] branch_edge_clr;
  logic core_req, core_wr, core_space_e, strobe_mode, page_e_we, page_c_we, internal_sel;
  logic [WORD_ADDR_W-1:0] core_addr;
  logic [DATA_W-1:0] core_wdata, core_rdata, local_data_bus_in, local_data_bus_out, ldata_drv;
  logic [PAGE_W-1:0] page_wdata;
  logic local_data_bus_oe, local_addr_bus_oe, ext_space_sel_n, data_strobe_n, write_dir_n;
  logic [ADDR_W-1:0] local_addr_bus;
  logic host_prog_wr, branch_take, instr_data_bus_oe, instr_addr_bus_oe, instr_is_nop;
  logic ext_prog_mem_enable_n, prog_mem_write_n;
  logic [IADDR_W-1:0] host_prog_addr, branch_target, instr_addr_bus;
  logic [IDATA_W-1:0] host_prog_data, instr_data_bus_in, instr_data_bus_out, fetched_instr;
  logic [IDATA_W-1:0] idata_drv;
  logic low_power_ack_n, machine_cycle_clock, instruction_cycle_clock;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  // Each shared line carries whichever party has its enable up.
  assign local_data_bus_in = local_data_bus_oe ? local_data_bus_out : ldata_drv;
  assign instr_data_bus_in = instr_data_bus_oe ? instr_data_bus_out : idata_drv;
  ext_bus_ctrl dut_u (
    .clk, .rst, .program_mode_select, .low_power_request_n, .lp_edge_mode, .halt_n, .nop_n,
    .level_branch_input, .edge_branch_input_a, .edge_branch_input_b, .branch_cond,
    .branch_edge_clr, .core_req, .core_wr, .core_space_e, .core_addr, .core_wdata, .strobe_mode,
    .page_e_we, .page_c_we, .page_wdata, .core_rdata, .internal_sel, .local_data_bus_in,
    .local_data_bus_out, .local_data_bus_oe, .local_addr_bus, .local_addr_bus_oe,
    .ext_space_sel_n, .data_strobe_n, .write_dir_n, .host_prog_wr, .host_prog_addr,
    .host_prog_data, .branch_take, .branch_target, .instr_data_bus_in, .instr_data_bus_out,
    .instr_data_bus_oe, .instr_addr_bus, .instr_addr_bus_oe, .ext_prog_mem_enable_n,
    .prog_mem_write_n, .fetched_instr, .instr_is_nop, .low_power_ack_n, .machine_cycle_clock,
    .instruction_cycle_clock);
  ext_mem_model mem_u (
    .clk, .strobe_mode, .local_addr_bus, .ext_space_sel_n, .data_strobe_n, .write_dir_n,
    .ldata_wire(local_data_bus_in), .ldata_drv, .instr_addr_bus, .ext_prog_mem_enable_n,
    .prog_mem_write_n, .idata_wire(instr_data_bus_in), .idata_drv);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_idle();
    chk({local_data_bus_oe, local_addr_bus, ext_space_sel_n, data_strobe_n, write_dir_n},
        {1'b0, ADDR_IDLE, 3'b111});
  endtask
  task automatic set_page(input logic e, input logic [3:0] p);
    @(posedge clk);
    page_e_we <= e;
    page_c_we <= !e;
    page_wdata <= p;
    @(posedge clk);
    page_e_we <= 1'b0;
    page_c_we <= 1'b0;
  endtask
  // Returns just after the edge that took the request, when the pins show it.
  task automatic access(input logic e, input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    core_req <= 1'b1;
    core_wr <= w;
    core_space_e <= e;
    core_addr <= a;
    core_wdata <= d;
    @(posedge clk);
    core_req <= 1'b0;
    #1;
  endtask
  task automatic t_clk();
    logic prev;
    tick(1);
    prev = machine_cycle_clock;
    repeat (6) begin
      tick(1);
      chk(machine_cycle_clock, !prev);
      chk(instruction_cycle_clock, machine_cycle_clock);
      prev = machine_cycle_clock;
    end
  endtask
  task automatic t_ext(input logic m);
    logic [15:0] d;
    logic [3:0]  p;
    d = m ? 16'hc3a5 : 16'h3c5a;
    p = m ? 4'h5 : 4'h4;
    @(posedge clk);
    strobe_mode <= m;
    set_page(1'b1, p);
    access(1'b1, 1'b1, 12'h0a5, d);
    chk(local_addr_bus, {p, 12'h0a5});
    chk(ext_space_sel_n, 1'b0);
    chk({local_data_bus_oe, local_data_bus_out}, {1'b1, d});
    chk({data_strobe_n, write_dir_n}, {!m, 1'b0});
    tick(1);
    chk_idle();
    access(1'b1, 1'b0, 12'h0a5, 16'h0000);
    chk({local_data_bus_oe, data_strobe_n, write_dir_n}, 3'b001);
    tick(1);
    chk(core_rdata, d);
  endtask
  task automatic t_int();
    set_page(1'b1, LAST_INT_PAGE);
    core_space_e <= 1'b1;
    core_req <= 1'b1;
    #1;
    chk(internal_sel, 1'b1);
    access(1'b1, 1'b1, 12'hfff, 16'h1234);
    chk_idle();
    set_page(1'b0, 4'h9);
    set_page(1'b1, 4'h4);
    access(1'b0, 1'b0, 12'h001, 16'h0000);
    chk(local_addr_bus, 16'h9001);
  endtask
  task automatic t_host();
    @(posedge clk);
    host_prog_wr <= 1'b1;
    host_prog_addr <= 16'h0042;
    host_prog_data <= 32'hc001_d00d;
    @(posedge clk);
    host_prog_wr <= 1'b0;
    #1;
    chk({prog_mem_write_n, ext_prog_mem_enable_n, instr_data_bus_oe}, 3'b001);
    chk(instr_addr_bus, 16'h0042);
    chk(instr_data_bus_out, 32'hc001_d00d);
    tick(1);
    chk(mem_u.pmem[8'h42], 32'hc001_d00d);
    chk(prog_mem_write_n, 1'b1);
  endtask
  task automatic t_pmode();
    @(posedge clk);
    program_mode_select <= 1'b1;
    branch_take <= 1'b1;
    branch_target <= 16'h0042;
    tick(6);
    chk(ext_prog_mem_enable_n, 1'b0);
    chk(fetched_instr, 32'hc001_d00d);
    @(posedge clk);
    program_mode_select <= 1'b0;
    tick(6);
    chk(ext_prog_mem_enable_n, 1'b1);
    @(posedge clk);
    branch_take <= 1'b1;
    branch_target <= 16'h8000;
    repeat (2) @(posedge clk);
    branch_take <= 1'b0;
    tick(4);
    chk({ext_prog_mem_enable_n, instr_addr_bus[15]}, 2'b01);
  endtask
  task automatic t_branch();
    @(posedge clk);
    level_branch_input <= 1'b0;
    tick(4);
    chk(branch_cond[0], 1'b1);
    @(posedge clk);
    level_branch_input <= 1'b1;
    edge_branch_input_a <= 1'b0;
    edge_branch_input_b <= 1'b0;
    @(posedge clk);
    edge_branch_input_a <= 1'b1;
    edge_branch_input_b <= 1'b1;
    tick(4);
    chk(branch_cond, 3'b110);
    @(posedge clk);
    branch_edge_clr <= 2'b01;
    @(posedge clk);
    branch_edge_clr <= 2'b00;
    tick(2);
    chk(branch_cond, 3'b100);
  endtask
  task automatic t_float(input logic h);
    @(posedge clk);
    if (h) halt_n <= 1'b0;
    else nop_n <= 1'b0;
    tick(8);
    chk({instr_addr_bus_oe, local_addr_bus_oe}, {1'b0, h});
    if (!h) chk({instr_data_bus_oe, local_data_bus_oe, instr_is_nop}, 3'b001);
    access(1'b1, 1'b1, 12'h010, 16'hffff);
    chk({local_data_bus_oe, ext_space_sel_n}, 2'b01);
    @(posedge clk);
    halt_n <= 1'b1;
    nop_n <= 1'b1;
    tick(8);
    chk({instr_addr_bus_oe, local_addr_bus_oe}, 2'b11);
  endtask
  task automatic t_lp(input logic e);
    @(posedge clk);
    lp_edge_mode <= e;
    low_power_request_n <= 1'b0;
    @(posedge clk);
    low_power_request_n <= e;
    // In edge mode a one-cycle pulse is enough to enter low power briefly.
    tick(4);
    chk(low_power_ack_n, 1'b0);
    @(posedge clk);
    low_power_request_n <= 1'b0;
    tick(10);
    chk(low_power_ack_n, 1'b0);
    access(1'b1, 1'b1, 12'h020, 16'h5555);
    chk({local_data_bus_oe, ext_space_sel_n}, 2'b01);
    @(posedge clk);
    low_power_request_n <= 1'b1;
    tick(10);
    chk(low_power_ack_n, 1'b1);
  endtask
  initial begin
    {program_mode_select, lp_edge_mode, branch_edge_clr, core_req, core_wr, core_space_e,
     core_addr, core_wdata, strobe_mode, page_e_we, page_c_we, page_wdata, host_prog_wr,
     host_prog_addr, host_prog_data, branch_take, branch_target} = '0;
    {low_power_request_n, halt_n, nop_n, level_branch_input, edge_branch_input_a,
     edge_branch_input_b} = '1;
    tick(8);
    chk_idle();
    chk({low_power_ack_n, instr_is_nop, machine_cycle_clock}, 3'b110);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_clk();
    t_ext(1'b0);
    t_ext(1'b1);
    t_int();
    t_host();
    t_pmode();
    t_branch();
    t_float(1'b1);
    t_float(1'b0);
    t_lp(1'b0);
    t_lp(1'b1);
    end_sim();
  end
endmodule // ext_bus_ctrl_tb
